// File: bench/hbi_interp_chain_asserts.sv
// Port checks for the half-band interpolator chain
`timescale 1ns/1ps
module hbi_interp_chain_asserts
   import hbi_pkg::*;
#(parameter int STAGES = 2) (
   // Clock and reset
   input wire logic              sys_clk,
   input wire logic              rstn,
   // Watched ports
   input wire logic [STAGES-1:0] stage_enable,
   input wire logic              in_valid,
   input wire logic              in_ready,
   input wire logic              out_valid,
   input wire hbi_sample_type    out_sample,
   input wire logic              out_ready,
   input wire logic [2:0]        rate_factor
);
   // One domain, so one clock and reset for all
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   property p_quiet;
      $rose(rstn) |-> !out_valid && !in_ready && rate_factor == 3'h1;
   endproperty
   a_quiet: assert property (p_quiet) else $error("chain busy after reset");
   // Factor follows the enables one cycle late
   property p_one;
      $past(rstn) && $past(stage_enable) == 2'h0 |-> rate_factor == 3'h1;
   endproperty
   a_one: assert property (p_one) else $error("bypass factor wrong");
   property p_first;
      $past(rstn) && $past(stage_enable) == 2'h1 |-> rate_factor == 3'h2;
   endproperty
   a_first: assert property (p_first) else $error("first stage factor wrong");
   property p_second;
      $past(rstn) && $past(stage_enable) == 2'h2 |-> rate_factor == 3'h2;
   endproperty
   a_second: assert property (p_second) else $error("second stage factor wrong");
   property p_four;
      $past(rstn) && $past(stage_enable) == 2'h3 |-> rate_factor == 3'h4;
   endproperty
   a_four: assert property (p_four) else $error("cascade factor wrong");
   property p_max;
      out_valid |-> rate_factor inside {3'h1, 3'h2, 3'h4};
   endproperty
   a_max: assert property (p_max) else $error("factor out of range");
   // A stalled word must not change under the actuator
   property p_hold;
      out_valid && !out_ready |=> out_valid && $stable(out_sample);
   endproperty
   a_hold: assert property (p_hold) else $error("output dropped in stall");
   property p_pass;
      in_valid && in_ready && stage_enable == 2'h0 |-> ##[1:30] out_valid;
   endproperty
   a_pass: assert property (p_pass) else $error("bypass word lost");
endmodule

bind hbi_interp_chain hbi_interp_chain_asserts #(.STAGES(STAGES)) hbi_chk_inst (
   .sys_clk(sys_clk), .rstn(rstn), .stage_enable(stage_enable),
   .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid),
   .out_sample(out_sample), .out_ready(out_ready), .rate_factor(rate_factor));

// File: bench/hbi_interp_chain_tb.sv
// Self-checking bench for the half-band interpolator chain
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
   $display("mismatch %0t %h %h", $time, a, b); end end
module hbi_interp_chain_tb;
   import hbi_pkg::*;
   logic           sys_clk = 1'b0, rstn = 1'b0, in_valid = 1'b0, slow = 1'b0;
   logic           in_ready, out_valid, out_ready;
   logic [1:0]     stage_enable = 2'h0;
   logic [2:0]     rate_factor;
   hbi_sample_type in_sample = '0, out_sample;
   hbi_sample_type got[64];
   int             n_got, n_fail = 0, samples_checked = 0;

   // 25 MHz clock
   initial forever #20 sys_clk = ~sys_clk;

   hbi_interp_chain #(.STAGES(2), .BUF_DEPTH(2)) hbi_interp_chain_inst (
      .sys_clk(sys_clk), .rstn(rstn), .stage_enable(stage_enable),
      .in_valid(in_valid), .in_sample(in_sample), .in_ready(in_ready),
      .out_valid(out_valid), .out_sample(out_sample), .out_ready(out_ready),
      .rate_factor(rate_factor));
   hbi_sink_model hbi_sink_model_inst (.sys_clk(sys_clk), .rstn(rstn),
      .slow(slow), .out_valid(out_valid), .out_ready(out_ready));

   // Log every word the sink takes, in order
   always @(posedge sys_clk) begin
      if (!rstn) n_got <= 0;
      else if (out_valid && out_ready) begin
         got[n_got] <= out_sample;
         n_got <= n_got + 1;
      end
   end

   // Small distinct words keep the odd phase far from saturation
   function automatic hbi_sample_type mk(int i);
      return 32'h00010002 * (i + 1);
   endfunction

   // Input word i, zero before the first one
   function automatic hbi_sample_type xin(int i);
      return (i < 0) ? hbi_sample_type'(32'h0) : mk(i);
   endfunction

   // Real part of input word i, zero history
   function automatic int cx(int i);
      return (i < 0) ? 0 : i + 1;
   endfunction

   // Odd phase after input k: taps -1 9 9 -1 over 16, imag part is twice real
   function automatic hbi_sample_type mid(int k);
      int s;
      s = 9 * (cx(k - 1) + cx(k - 2)) - cx(k) - cx(k - 3);
      return {16'(s >>> 4), 16'((2 * s) >>> 4)};
   endfunction

   task test_done;
      if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Reset into one mode, stream n words, check count, factor and even phase
   task run(input logic [1:0] en, input int n, input logic stl, input int f);
      int   k, t, d;
      logic rdy;
      rstn <= 1'b0;
      stage_enable <= en;
      slow <= stl;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      for (k = 0; k < n; k++) begin
         in_valid <= 1'b1;
         in_sample <= mk(k);
         t = 0;
         // Hold the word until in_ready is seen at the taking edge
         do begin
            @(negedge sys_clk);
            rdy = in_ready;
            @(posedge sys_clk);
            t++;
         end while (!rdy && t < 200);
         if (!rdy) begin n_fail++; test_done; end
      end
      in_valid <= 1'b0;
      for (t = 0; t < 300 && n_got < n * f; t++) @(posedge sys_clk);
      if (n_got < n * f) begin n_fail++; test_done; end
      repeat (4) @(posedge sys_clk);
      `CHK(n_got, n * f)
      `CHK(rate_factor, 3'(f))
      // Even phase lags by the center-tap delay, odd phase sits between its neighbours
      d = (f == 1) ? 0 : ((f == 2) ? 2 : 3);
      for (k = 0; k < n; k++) begin
         `CHK(got[k * f], xin(k - d))
         if (f == 2) `CHK(got[2 * k + 1], mid(k))
         if (f == 4) `CHK(got[4 * k + 2], mid(k - 1))
      end
   endtask

   initial begin
      run(2'h0, 8, 1'b0, 1);
      run(2'h1, 6, 1'b1, 2);
      run(2'h2, 6, 1'b0, 2);
      run(2'h3, 5, 1'b1, 4);
      test_done;
   end
endmodule

// File: bench/hbi_sink_model.sv
// Actuator-side sink that can accept every cycle or stall
`timescale 1ns/1ps
module hbi_sink_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Stall pattern select
   input wire logic slow,
   // Stream from the chain
   input wire logic out_valid,
   output logic     out_ready
);
   logic [1:0] tick_reg;
   // Count offered cycles, slow mode takes one word in four
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         tick_reg <= 2'h0;
      end else if (out_valid) begin
         tick_reg <= tick_reg + 2'h1;
      end
   end
   // Three-cycle stalls fill the buffer ahead
   assign out_ready = rstn && (!slow || tick_reg == 2'h3);
endmodule

// File: logic/hbi_interp_chain.sv
// Two cascadable half-band interpolators ahead of the predistortion actuator
`timescale 1ns/1ps
`include "hbi_params.svh"

// Functional notes
// - two half-band stages, each independently bypassable
// - each stage passes 1x or interpolates 2x
// - both enabled cascade to 4x, no more
// - maximally flat, no ripple, edges symmetric about quarter rate
// - first stage passes about 82 percent bandwidth
// - second stage shares the first stage's taps, so the same relative bandwidth
// - chain output feeds the predistortion actuator
module hbi_interp_chain
   import hbi_pkg::*;
#(
   parameter int STAGES = `HBI_STAGES,
   parameter int BUF_DEPTH = `HBI_BUF_DEPTH
) (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   // Stage enables, bit 0 first stage, bit 1 second stage
   input  wire logic [STAGES-1:0] stage_enable,
   // Baseband input from deframer or peak reduction
   input  wire logic              in_valid,
   input  wire hbi_sample_type    in_sample,
   output logic                   in_ready,
   // Interpolated output toward the actuator
   output logic                   out_valid,
   output hbi_sample_type         out_sample,
   input  wire logic              out_ready,
   // Current overall interpolation factor (1, 2 or 4)
   output logic [2:0]             rate_factor
);
   localparam int W  = `HBI_SAMPLE_W;
   localparam int SW = W + 6;

   // same taps, doubled input rate
   // Odd-phase half-band output for one component
   function automatic logic signed [W-1:0] odd_phase(
      input logic signed [W-1:0] d0,
      input logic signed [W-1:0] d1,
      input logic signed [W-1:0] d2,
      input logic signed [W-1:0] d3
   );
      logic signed [SW-1:0] acc;
      logic signed [SW-1:0] lim_hi;
      logic signed [SW-1:0] lim_lo;
      acc = SW'(`HBI_TAP_INNER) * (SW'(d1) + SW'(d2))
          - SW'(`HBI_TAP_OUTER) * (SW'(d0) + SW'(d3));
      acc = acc >>> `HBI_COEF_SHIFT;
      lim_hi = SW'({1'b0, {(W-1){1'b1}}});
      lim_lo = -lim_hi - SW'(1);
      // Saturate: overshoot near full scale must not wrap
      if (acc > lim_hi) begin
         odd_phase = lim_hi[W-1:0];
      end else if (acc < lim_lo) begin
         odd_phase = lim_lo[W-1:0];
      end else begin
         odd_phase = acc[W-1:0];
      end
   endfunction

   // Links between stages: index 0 is the buffer output, STAGES the chain output
   logic           lnk_valid [STAGES+1];
   logic           lnk_ready [STAGES+1];
   hbi_sample_type lnk_data  [STAGES+1];

   // Input buffer so a stall downstream never drops an offered word
   hbi_pair_buffer #(
      .WIDTH (2*W),
      .DEPTH (BUF_DEPTH)
   ) u_in_buf (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .in_valid  (in_valid),
      .in_data   (in_sample),
      .in_ready  (in_ready),
      .out_valid (lnk_valid[0]),
      .out_data  (lnk_data[0]),
      .out_ready (lnk_ready[0])
   );

   genvar s;
   generate
      for (s = 0; s < STAGES; s++) begin : g_stage
         hbi_state_type  state_reg;
         hbi_sample_type win_reg [`HBI_WIN];
         logic           ov_reg;
         hbi_sample_type od_reg;
         logic           out_free;
         logic           take;
         logic           en;

         // Output slot frees when empty or being drained
         assign out_free = !ov_reg || lnk_ready[s+1];
         assign en       = stage_enable[s];
         assign take     = lnk_valid[s] && lnk_ready[s];

         // one input per pass, hold during second phase
         assign lnk_ready[s] = out_free && (state_reg == HBI_TAKE);

         assign lnk_valid[s+1] = ov_reg;
         assign lnk_data[s+1]  = od_reg;

         // History window, shifted only on accepted input
         always_ff @(posedge sys_clk) begin
            if (!rstn) begin
               for (int k = 0; k < `HBI_WIN; k++) begin
                  win_reg[k] <= '0;
               end
            end else if (take && en) begin
               win_reg[0] <= lnk_data[s];
               for (int k = 1; k < `HBI_WIN; k++) begin
                  win_reg[k] <= win_reg[k-1];
               end
            end
         end

         // Phase sequencing and output register
         always_ff @(posedge sys_clk) begin
            if (!rstn) begin
               state_reg <= HBI_TAKE;
               ov_reg    <= 1'b0;
               od_reg    <= '0;
            end else begin
               unique case (state_reg)
                  HBI_TAKE: begin
                     if (take && !en) begin
                        od_reg <= lnk_data[s];
                        ov_reg <= 1'b1;
                     end else if (take) begin
                        // center tap, two back
                        // Two-input delay keeps the odd taps symmetric about it
                        od_reg <= win_reg[1];
                        ov_reg <= 1'b1;
                        state_reg <= HBI_SECOND;
                     end else if (out_free) begin
                        ov_reg <= 1'b0;
                     end
                  end
                  HBI_SECOND: begin
                     if (out_free) begin
                        od_reg.re <= odd_phase(win_reg[0].re, win_reg[1].re,
                                               win_reg[2].re, win_reg[3].re);
                        od_reg.im <= odd_phase(win_reg[0].im, win_reg[1].im,
                                               win_reg[2].im, win_reg[3].im);
                        ov_reg    <= 1'b1;
                        state_reg <= HBI_TAKE;
                     end
                  end
               endcase
            end
         end
      end
   endgenerate

   assign lnk_ready[STAGES] = out_ready;
   assign out_valid         = lnk_valid[STAGES];
   assign out_sample        = lnk_data[STAGES];

   // factor is 1, 2 or 4 only
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rate_factor <= `HBI_FACTOR_RST;
      end else begin
         unique case (stage_enable[1:0])
            2'h0:    rate_factor <= 3'h1;
            2'h3:    rate_factor <= 3'(`HBI_MAX_FACTOR);
            default: rate_factor <= 3'h2;
         endcase
      end
   end

   // Both stages share one short tap set; a longer kernel would sharpen the
   // transition band at the cost of window depth and latency.
endmodule

// File: logic/hbi_pair_buffer.sv
// Small elastic buffer with valid/ready on both sides
`timescale 1ns/1ps
`include "hbi_params.svh"
module hbi_pair_buffer
   import hbi_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = `HBI_BUF_DEPTH
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   // Filling side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // Draining side
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic [AW:0]      count_next;
   logic             push;
   logic             pop;

   // Handshakes on both sides
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_valid = (count_reg != '0);
   assign out_data  = mem_reg[rd_ptr_reg];

   // Occupancy after this cycle
   always_comb begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop && !push) begin
         count_next = count_reg - 1'b1;
      end
   end

   // Ready is registered so the upstream sees no combinational path
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         count_reg <= '0;
         in_ready  <= 1'b0;
      end else begin
         count_reg <= count_next;
         in_ready  <= (count_next < (AW+1)'(DEPTH));
      end
   end

   // Storage and pointers, wrapping at the depth
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule

// File: logic/hbi_params.svh
// Constants for the two-stage half-band interpolator chain
`ifndef HBI_PARAMS_SVH
`define HBI_PARAMS_SVH

// Sample component width, per I and Q
`define HBI_SAMPLE_W    16
// Number of cascaded half-band stages; two stages give at most 4x
`define HBI_STAGES      2
// Highest overall interpolation factor
`define HBI_MAX_FACTOR  4
// Window of input samples one odd output depends on
`define HBI_WIN         4
// Odd-phase taps: inner pair weight, outer pair weight, scale shift
`define HBI_TAP_INNER   9
`define HBI_TAP_OUTER   1
`define HBI_COEF_SHIFT  4
// Entries of the input elastic buffer
`define HBI_BUF_DEPTH   2
// Reset value of the reported interpolation factor
`define HBI_FACTOR_RST  3'h1

`endif

// File: logic/hbi_pkg.sv
// Types shared by the half-band interpolator chain
package hbi_pkg;
`include "hbi_params.svh"

   // One complex baseband sample
   typedef struct packed {
      logic signed [`HBI_SAMPLE_W-1:0] re;
      logic signed [`HBI_SAMPLE_W-1:0] im;
   } hbi_sample_type;

   // Per-stage sequencing, one-hot
   typedef enum logic [1:0] {
      HBI_TAKE   = 2'b01,
      HBI_SECOND = 2'b10
   } hbi_state_type;

endpackage
